// ---- src/dmc_counter_pair.sv ----
// One counter device: two independent 8-bit up-counters, shared data port.
// Assumes counter clocks and load strobe are sampled levels on clk.
`timescale 1ns/100ps
module dmc_counter_pair (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // Control
    input  wire dmc_pkg::dmc_dev_ctl_type ctl,
    // Data port
    input  wire logic [7:0]               dataIn,
    output logic      [7:0]               dataOut,
    output logic                          dataOe_n,
    // Terminal counts
    output logic                          firstMax,
    output logic                          secondMax
);
    import dmc_pkg::*;

    logic [7:0] firstCount_q;
    logic [7:0] firstCount_d;
    logic [7:0] secondCount_q;
    logic [7:0] secondCount_d;
    logic [7:0] dataOut_q;
    logic [2:0] fall;
    logic       firstFall;
    logic       secondFall;
    logic       loadFall;
    logic       loadFirst;
    logic       loadSecond;
    logic       readFirst;
    logic       readSecond;
    logic [7:0] firstStep;

    function automatic logic tcHit(input logic [7:0] count, input logic byTwo);
        tcHit = (count == (byTwo ? TC_BY_TWO : TC_BY_ONE));
    endfunction

    dmc_edge_sense #(.WIDTH(3)) edges (
        .clk     (clk),
        .reset_n (reset_n),
        .level   ({ctl.loadStrobe, ctl.secondClk, ctl.firstClk}),
        .rise    (),
        .fall    (fall)
    );

    assign firstFall  = fall[0];
    assign secondFall = fall[1];
    assign loadFall   = fall[2];
    assign loadFirst  = loadFall & ctl.firstSelect & ~ctl.secondSelect;  // (R6) (R22)
    assign loadSecond = loadFall & ctl.secondSelect & ~ctl.firstSelect;  // (R6) (R22)
    assign readFirst  = ctl.readStrobe & ctl.firstRead & ctl.firstSelect & ~ctl.secondSelect;  // (R22)
    assign readSecond = ctl.readStrobe & ~ctl.firstRead & ctl.secondSelect & ~ctl.firstSelect;  // (R22)
    // Adding two leaves the least significant bit untouched
    assign firstStep  = ctl.stepSelect ? STEP_TWO : STEP_ONE;  // (R1)

    // Load wins over a count edge in the same cycle
    assign firstCount_d  = loadFirst  ? dataIn :
                           firstFall  ? firstCount_q + firstStep :  // (R3)
                           firstCount_q;
    assign secondCount_d = loadSecond ? dataIn :
                           secondFall ? secondCount_q + STEP_ONE :  // (R5)
                           secondCount_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            firstCount_q  <= CNT_RESET;
            secondCount_q <= CNT_RESET;
            dataOut_q     <= CNT_RESET;
        end else begin
            firstCount_q  <= firstCount_d;
            secondCount_q <= secondCount_d;
            dataOut_q     <= ctl.firstRead ? firstCount_q : secondCount_q;
        end
    end

    assign dataOut   = dataOut_q;
    assign dataOe_n  = ~(readFirst | readSecond);  // (R8)
    assign firstMax  = ctl.firstClk & tcHit(firstCount_q, ctl.stepSelect);  // (R9)
    assign secondMax = ctl.secondClk & tcHit(secondCount_q, 1'b0);  // (R10)

    chk_first_by_one: assert property (@(posedge clk) disable iff (!reset_n)  // (R1)
        firstFall && !loadFirst && !ctl.stepSelect |=> firstCount_q == $past(firstCount_q) + STEP_ONE)
        else $error("first counter did not step by one");
    chk_first_by_two: assert property (@(posedge clk) disable iff (!reset_n)  // (R3)
        firstFall && !loadFirst && ctl.stepSelect
        |=> firstCount_q == $past(firstCount_q) + STEP_TWO && firstCount_q[0] == $past(firstCount_q[0]))
        else $error("first counter did not step by two");
    chk_second_by_one: assert property (@(posedge clk) disable iff (!reset_n)  // (R5)
        secondFall && !loadSecond |=> secondCount_q == $past(secondCount_q) + STEP_ONE)
        else $error("second counter did not step by one");
    chk_load_value: assert property (@(posedge clk) disable iff (!reset_n)  // (R6)
        loadFall && ctl.firstSelect && !ctl.secondSelect |=> firstCount_q == $past(dataIn))
        else $error("load strobe fall did not load");
    chk_drive_only_read: assert property (@(posedge clk) disable iff (!reset_n)  // (R8)
        !ctl.readStrobe |-> dataOe_n)
        else $error("data port driven outside a read");
    chk_second_max: assert property (@(posedge clk) disable iff (!reset_n)  // (R10)
        ctl.secondClk && secondCount_q == TC_BY_ONE |-> secondMax)
        else $error("second terminal count missed");
endmodule

// ---- src/dmc_dma_top.sv ----
// DMA block: cascaded address and word counters plus bus-mastership sequencer.
// Assumes all inputs synchronous to clk; the 8 MHz strobe clock is a sampled input.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
// Functional notes
// (R1) Step select low counts one, high counts two
// (R2) User ties step select low on high device
// (R3) First counter steps on its clock falling
// (R4) User holds step and load steady while clock high
// (R5) Second counter steps by one on falling clock
// (R6) Load strobe fall loads the selected counter
// (R7) User keeps data steady while load low
// (R8) Eight-bit port, driven only during reads
// (R9) First max: clock AND 376 or 377
// (R10) Second max: clock AND count 377
// (R11) Two devices cascade into 16-bit counters
// (R12) Request starts transaction; dropping it ends mastership
// (R13) Grant takes mastership, else passed on delayed
// (R14) Limit high releases bus after four transfers
// (R15) Holdoff pin driven low while permit high
// (R16) Holdoff low blocks request; rise re-requests
// (R17) Select inputs choose read, write or read-modify-write
// (R18) User toggles modify select to finish output half
// (R19) Strobe timing paced by the 8 MHz clock
// (R20) Mastership needs sync, reply and permit together
// (R21) Initialize negates all bus outputs, waits request; grant out is not gated by initialize and can still pass on
// (R22) Selects decode to exactly one counter
// (R23) Cycle select encoding for read, write, modify
module dmc_dma_top (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Counter control
    input  wire dmc_pkg::dmc_cnt_in_type cntIn,
    // Counter data ports, one byte per device
    input  wire logic [1:0][7:0]         counterDataIn,
    output logic      [1:0][7:0]         counterDataOut,
    output logic      [1:0]              counterDataOe_n,
    // Counter terminal counts
    output logic      [1:0]              firstMax,
    output logic      [1:0]              secondMax,
    // Sequencer inputs
    input  wire dmc_pkg::dmc_seq_in_type seqIn,
    // Sequencer bus strobes
    output dmc_pkg::dmc_bus_out_type     busOut,
    // Open-collector pins, low while enable low
    output logic                         dmaRequestOe_n,
    output logic                         grantOutOe_n,
    output logic                         holdoffOut,
    output logic                         holdoffOe_n
);
    import dmc_pkg::*;

    dmc_dev_ctl_type   devCtl [DEV_COUNT];
    dmc_seq_state_type state_q;
    dmc_seq_state_type state_d;
    dmc_cycle_type     cycle_q;
    dmc_cycle_type     cycle_d;
    dmc_cycle_type     cycleSel;
    logic [2:0]        xferCount_q;
    logic [2:0]        xferCount_d;
    logic [2:0]        xferNext;
    logic              modifyLevel_q;
    logic              modifyLevel_d;
    logic [GRANT_DELAY-1:0] grantDly_q;
    logic              seqTick;
    logic              seqRise;
    logic              reqPending;
    logic              masterReady;
    logic              limitReached;
    logic              inMaster;
    logic              initOk;

    // Counters
    // Low device carries into the high one through its max outputs
    always_comb begin
        devCtl[DEV_LOW].stepSelect    = cntIn.stepSelect;
        devCtl[DEV_LOW].firstClk      = cntIn.addrClock;
        devCtl[DEV_LOW].secondClk     = cntIn.wordClock;
        devCtl[DEV_HIGH].stepSelect   = 1'b0;  // (R2)
        devCtl[DEV_HIGH].firstClk     = firstMax[DEV_LOW];  // (R11)
        devCtl[DEV_HIGH].secondClk    = secondMax[DEV_LOW];  // (R11)
        for (int i = 0; i < DEV_COUNT; i++) begin
            devCtl[i].loadStrobe   = cntIn.loadStrobe;
            devCtl[i].readStrobe   = cntIn.readStrobe;
            devCtl[i].firstRead    = cntIn.firstRead;
            devCtl[i].firstSelect  = cntIn.firstSelect[i];
            devCtl[i].secondSelect = cntIn.secondSelect[i];
        end
    end

    for (genvar g = 0; g < DEV_COUNT; g++) begin : gen_dev
        dmc_counter_pair counter (
            .clk       (clk),
            .reset_n   (reset_n),
            .ctl       (devCtl[g]),
            .dataIn    (counterDataIn[g]),
            .dataOut   (counterDataOut[g]),
            .dataOe_n  (counterDataOe_n[g]),
            .firstMax  (firstMax[g]),
            .secondMax (secondMax[g])
        );
    end

    // Sequencer
    dmc_edge_sense #(.WIDTH(1)) seqEdge (
        .clk     (clk),
        .reset_n (reset_n),
        .level   (seqIn.seqClock),
        .rise    (seqRise),
        .fall    ()
    );

    // Every state step except the initialize return to idle waits for an 8 MHz rising edge
    assign seqTick     = seqRise;  // (R19)
    assign initOk      = seqIn.globalInit_n;
    assign reqPending  = (state_q == ST_REQUEST) || (state_q == ST_GRANTED);
    assign masterReady = seqIn.syncSeen & seqIn.replySeen & seqIn.mastershipPermit;  // (R20)
    assign cycleSel    = !seqIn.readModifyCycleSelect_n ? CYC_RMW :
                         !seqIn.readCycleSelect_n        ? CYC_READ : CYC_WRITE;  // (R17) (R23)
    assign xferNext    = (xferCount_q == XFER_LIMIT) ? XFER_LIMIT : xferCount_q + XFER_ONE;
    assign limitReached = seqIn.fourTransferLimit && (xferNext == XFER_LIMIT);  // (R14)
    assign inMaster    = (state_q == ST_ADDRESS) || (state_q == ST_READ) || (state_q == ST_MODIFY)
                         || (state_q == ST_WRITE) || (state_q == ST_FINISH);

    always_comb begin
        state_d       = state_q;
        cycle_d       = cycle_q;
        xferCount_d   = xferCount_q;
        modifyLevel_d = modifyLevel_q;
        if (!initOk) begin
            state_d     = ST_IDLE;  // (R21)
            xferCount_d = XFER_RESET;
        end else if (seqTick) begin
            case (state_q)
                ST_IDLE: begin
                    if (seqIn.mastershipRequest && seqIn.holdoffIn) begin
                        state_d = ST_REQUEST;  // (R12) (R16)
                    end
                end
                ST_REQUEST: begin
                    if (!seqIn.mastershipRequest) begin
                        state_d = ST_IDLE;  // (R12)
                    end else if (!seqIn.grantIn_n) begin
                        state_d = ST_GRANTED;  // (R13)
                    end
                end
                ST_GRANTED: begin
                    if (masterReady) begin
                        state_d       = ST_ADDRESS;  // (R20)
                        cycle_d       = cycleSel;
                        modifyLevel_d = seqIn.readModifyCycleSelect_n;
                        xferCount_d   = XFER_RESET;
                    end
                end
                ST_ADDRESS: begin
                    state_d = (cycle_q == CYC_WRITE) ? ST_WRITE : ST_READ;  // (R17)
                end
                ST_READ: begin
                    if (seqIn.replySeen) begin
                        state_d = (cycle_q == CYC_RMW) ? ST_MODIFY : ST_FINISH;  // (R20)
                    end
                end
                ST_MODIFY: begin
                    // Output half waits for the user to toggle the modify select
                    if (seqIn.readModifyCycleSelect_n != modifyLevel_q) begin
                        state_d = ST_WRITE;  // (R18)
                    end
                end
                ST_WRITE: begin
                    if (seqIn.replySeen) begin
                        state_d = ST_FINISH;  // (R20)
                    end
                end
                ST_FINISH: begin
                    xferCount_d = xferNext;
                    if (!seqIn.mastershipRequest) begin
                        state_d = ST_IDLE;  // (R12)
                    end else if (limitReached) begin
                        state_d = ST_HOLDOFF;  // (R14)
                    end else begin
                        state_d       = ST_ADDRESS;
                        cycle_d       = cycleSel;
                        modifyLevel_d = seqIn.readModifyCycleSelect_n;
                    end
                end
                ST_HOLDOFF: begin
                    // An external RC on the holdoff pin sets the wait
                    if (seqIn.holdoffIn) begin
                        state_d = seqIn.mastershipRequest ? ST_REQUEST : ST_IDLE;  // (R16)
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q       <= ST_IDLE;
            cycle_q       <= CYC_READ;
            xferCount_q   <= XFER_RESET;
            modifyLevel_q <= 1'b1;
        end else begin
            state_q       <= state_d;
            cycle_q       <= cycle_d;
            xferCount_q   <= xferCount_d;
            modifyLevel_q <= modifyLevel_d;
        end
    end

    // Grant passes down the chain two cycles late when nothing is pending
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            grantDly_q <= '0;
        end else begin
            grantDly_q <= {grantDly_q[GRANT_DELAY-2:0], !seqIn.grantIn_n && !reqPending};  // (R13)
        end
    end

    // Outputs
    assign grantOutOe_n   = ~grantDly_q[GRANT_DELAY-1];  // (R13)
    assign dmaRequestOe_n = ~(initOk && state_q == ST_REQUEST && seqIn.holdoffIn);  // (R16) (R21)
    assign holdoffOut     = 1'b0;
    assign holdoffOe_n    = ~seqIn.mastershipPermit;  // (R15)

    always_comb begin
        busOut.master        = initOk && inMaster;  // (R21)
        busOut.selectAck     = initOk && (inMaster || state_q == ST_GRANTED);
        busOut.addressEnable = initOk && state_q == ST_ADDRESS;
        busOut.syncOut       = initOk && inMaster && state_q != ST_FINISH;
        busOut.dataInStrobe  = initOk && state_q == ST_READ;
        busOut.dataOutStrobe = initOk && state_q == ST_WRITE;
        busOut.dataEnable_n  = ~(initOk && state_q == ST_WRITE);
    end

    chk_request_start: assert property (@(posedge clk) disable iff (!reset_n)  // (R12)
        state_q == ST_IDLE && seqTick && initOk && seqIn.mastershipRequest && seqIn.holdoffIn
        |=> state_q == ST_REQUEST ##0 !dmaRequestOe_n || !seqIn.holdoffIn || !initOk)
        else $error("request not raised");
    chk_request_drop: assert property (@(posedge clk) disable iff (!reset_n)  // (R12)
        state_q == ST_FINISH && seqTick && initOk && !seqIn.mastershipRequest |=> !busOut.master)
        else $error("mastership kept after request dropped");
    chk_grant_taken: assert property (@(posedge clk) disable iff (!reset_n)  // (R13)
        state_q == ST_REQUEST && seqTick && initOk && seqIn.mastershipRequest && !seqIn.grantIn_n
        |=> state_q == ST_GRANTED)
        else $error("grant not taken");
    chk_grant_pass: assert property (@(posedge clk) disable iff (!reset_n)  // (R13)
        (!seqIn.grantIn_n && !reqPending) [*2] |=> !grantOutOe_n)
        else $error("grant not passed on");
    chk_grant_block: assert property (@(posedge clk) disable iff (!reset_n)  // (R13)
        reqPending |-> ##2 grantOutOe_n)
        else $error("grant passed while pending");
    chk_four_limit: assert property (@(posedge clk) disable iff (!reset_n)  // (R14)
        state_q == ST_ADDRESS && $past(state_q) == ST_FINISH && $past(seqIn.fourTransferLimit)
        |-> xferCount_q < XFER_LIMIT)
        else $error("more than four transfers");
    chk_holdoff_drive: assert property (@(posedge clk) disable iff (!reset_n)  // (R15)
        seqIn.mastershipPermit |-> !holdoffOe_n && !holdoffOut)
        else $error("holdoff not driven low");
    chk_holdoff_block: assert property (@(posedge clk) disable iff (!reset_n)  // (R16)
        !seqIn.holdoffIn |-> dmaRequestOe_n)
        else $error("request asserted during holdoff");
    chk_cycle_write: assert property (@(posedge clk) disable iff (!reset_n)  // (R17)
        busOut.dataInStrobe |-> cycle_q != CYC_WRITE)
        else $error("read strobe in a write cycle");
    chk_master_cond: assert property (@(posedge clk) disable iff (!reset_n)  // (R20)
        $rose(busOut.master) |-> $past(masterReady) && $past(state_q) == ST_GRANTED)
        else $error("mastership without sync, reply and permit");
    chk_init_negate: assert property (@(posedge clk) disable iff (!reset_n)  // (R21)
        !initOk |-> !busOut.master && !busOut.syncOut && !busOut.dataInStrobe
        && !busOut.dataOutStrobe && busOut.dataEnable_n && dmaRequestOe_n ##1 state_q == ST_IDLE)
        else $error("outputs active during initialize");
endmodule

// ---- src/dmc_edge_sense.sv ----
// Rise and fall detector for sampled levels.
// Assumes the levels are synchronous to clk.
`timescale 1ns/100ps
module dmc_edge_sense #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Levels and their edges
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_q;

    // Reset to low so a level held low never reports a false fall
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
endmodule

// ---- src/dmc_pkg.sv ----
// Package for the DMA counter and bus-mastership block.
// Assumes one 40 MHz system clock; all other clocks arrive as sampled levels.
package dmc_pkg;
    localparam int         CNT_WIDTH   = 8;
    localparam logic [7:0] CNT_RESET   = 8'h00;
    localparam logic [7:0] TC_BY_ONE   = 8'hFF;
    localparam logic [7:0] TC_BY_TWO   = 8'hFE;
    localparam logic [7:0] STEP_ONE    = 8'h01;
    localparam logic [7:0] STEP_TWO    = 8'h02;
    localparam logic [2:0] XFER_RESET  = 3'h0;
    localparam logic [2:0] XFER_ONE    = 3'h1;
    localparam logic [2:0] XFER_LIMIT  = 3'h4;
    localparam int         GRANT_DELAY = 2;
    localparam int         DEV_LOW     = 0;
    localparam int         DEV_HIGH    = 1;
    localparam int         DEV_COUNT   = 2;

    typedef enum logic [1:0] {
        CYC_READ  = 2'h0,
        CYC_WRITE = 2'h1,
        CYC_RMW   = 2'h2
    } dmc_cycle_type;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_REQUEST = 4'h1,
        ST_GRANTED = 4'h2,
        ST_ADDRESS = 4'h3,
        ST_READ    = 4'h4,
        ST_MODIFY  = 4'h5,
        ST_WRITE   = 4'h6,
        ST_FINISH  = 4'h7,
        ST_HOLDOFF = 4'h8
    } dmc_seq_state_type;

    // Control of one counter device
    typedef struct packed {
        logic stepSelect;
        logic firstClk;
        logic secondClk;
        logic loadStrobe;
        logic readStrobe;
        logic firstRead;
        logic firstSelect;
        logic secondSelect;
    } dmc_dev_ctl_type;

    // User-side control of the cascaded counter pair
    typedef struct packed {
        logic       stepSelect;
        logic       addrClock;
        logic       wordClock;
        logic       loadStrobe;
        logic       readStrobe;
        logic       firstRead;
        logic [1:0] firstSelect;
        logic [1:0] secondSelect;
    } dmc_cnt_in_type;

    // Sequencer inputs
    typedef struct packed {
        logic seqClock;
        logic mastershipRequest;
        logic grantIn_n;
        logic fourTransferLimit;
        logic mastershipPermit;
        logic holdoffIn;
        logic readCycleSelect_n;
        logic readModifyCycleSelect_n;
        logic syncSeen;
        logic replySeen;
        logic globalInit_n;
    } dmc_seq_in_type;

    // Sequencer bus strobes
    typedef struct packed {
        logic master;
        logic dataEnable_n;
        logic addressEnable;
        logic syncOut;
        logic dataInStrobe;
        logic dataOutStrobe;
        logic selectAck;
    } dmc_bus_out_type;
endpackage

// ---- test/dma_counter_and_bus_master_bench.sv ----
// Bench for the DMA counter pair and bus-mastership sequencer.
// Assumes the bus partner model answers on the sequencer side.
`timescale 1ns/100ps
module dma_counter_and_bus_master_bench;
    import dmc_pkg::*;
    logic            clk = 0, reset_n = 0, probe = 0, grantIdle = 0, req = 0, rdSel_n = 0, init_n = 1, permit = 1;
    logic            prevStb = 0, dmaRequestOe_n, grantOutOe_n, holdoffOut, holdoffOe_n, modSel_n = 1;
    logic            seqClock, grantIn_n, syncSeen, replySeen, holdoffIn;
    logic [15:0]     expQ[$];
    logic [1:0][7:0] counterDataIn = '0, counterDataOut;
    logic [1:0]      counterDataOe_n, firstMax, secondMax;
    logic [7:0]      v;
    int              miscompares = 0, num_checks = 0, xfers = 0, n;
    dmc_cnt_in_type  cntIn = '0;
    dmc_seq_in_type  seqIn;
    dmc_bus_out_type busOut;
    assign seqIn = '{seqClock, req, grantIn_n, 1'b1, permit, holdoffIn,
                     rdSel_n, modSel_n, syncSeen, replySeen, init_n};
    dmc_dma_top dut (.clk(clk), .reset_n(reset_n), .cntIn(cntIn), .counterDataIn(counterDataIn),
        .counterDataOut(counterDataOut), .counterDataOe_n(counterDataOe_n), .firstMax(firstMax),
        .secondMax(secondMax), .seqIn(seqIn), .busOut(busOut), .dmaRequestOe_n(dmaRequestOe_n),
        .grantOutOe_n(grantOutOe_n), .holdoffOut(holdoffOut), .holdoffOe_n(holdoffOe_n));
    dmc_bus_partner bus (.clk(clk), .dmaRequestOe_n(dmaRequestOe_n), .holdoffOe_n(holdoffOe_n),
        .busOut(busOut), .grantIdle(grantIdle), .seqClock(seqClock), .grantIn_n(grantIn_n),
        .syncSeen(syncSeen), .replySeen(replySeen), .holdoffIn(holdoffIn));
    initial forever #12.5 clk = ~clk;
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask
    // Clocks rest low and load rests high, so data only moves while load is high
    task automatic pulse(input int w, input int k);
        repeat (k) begin
            ticks(1);
            {cntIn.addrClock, cntIn.wordClock, cntIn.loadStrobe} <= {cntIn.addrClock, cntIn.wordClock, cntIn.loadStrobe} ^ 3'(4 >> w);
            ticks(2);
            {cntIn.addrClock, cntIn.wordClock, cntIn.loadStrobe} <= {cntIn.addrClock, cntIn.wordClock, cntIn.loadStrobe} ^ 3'(4 >> w);
            ticks(1);
        end
        ticks(3);
    endtask
    task automatic expect16(input logic [15:0] e);
        expQ.push_back(e);
        probe <= 1'b1;
        ticks(1);
        probe <= 1'b0;
    endtask
    task automatic waitFor(input int which, input logic lvl);
        int i;
        for (i = 0; i < 600; i++) begin
            if ((which == 2 ? busOut.selectAck : which ? dmaRequestOe_n : busOut.master) === lvl) break;
            ticks(1);
        end
        if (i == 600) begin
            miscompares++;
            $display("[ERR] %0t wait ran out", $time);
            conclude();
        end
    endtask
    always @(posedge clk)
        if (probe && expQ.size() > 0) check(counterDataOut, expQ.pop_front());
    always @(posedge clk) begin
        prevStb <= rdSel_n ? busOut.dataOutStrobe : busOut.dataInStrobe;
        if ((rdSel_n ? busOut.dataOutStrobe : busOut.dataInStrobe) && !prevStb) xfers++;
    end
    initial begin
        void'($urandom(32'h1E910305));
        {cntIn.loadStrobe, cntIn.readStrobe, cntIn.firstRead, cntIn.firstSelect} = 5'h1F;
        ticks(5);
        reset_n <= 1'b1;
        ticks(2);
        check({busOut, dmaRequestOe_n, grantOutOe_n}, 16'h0083);
        for (int m = 0; m < 2; m++) begin
            v = 8'($urandom_range(0, 8'hF0));
            n = $urandom_range(1, 5);
            cntIn.stepSelect <= m[0];
            counterDataIn <= {8'h00, v};
            pulse(2, 1);
            pulse(0, n);
            expect16({8'h00, m ? {v[7:1] + 7'(n), v[0]} : v + 8'(n)});
        end
        cntIn.stepSelect <= 1'b0;
        counterDataIn <= 16'h12FF;
        pulse(2, 1);
        pulse(0, 1);
        expect16(16'h1300);
        for (int k = 0; k < 4; k++) begin
            cntIn.stepSelect <= k[1];
            counterDataIn <= {8'h00, k[1] ? (k[0] ? 8'hFC : 8'hFE) : (k[0] ? 8'hFE : 8'hFF)};
            pulse(2, 1);
            check(firstMax[0], 1'b0);
            cntIn.addrClock <= 1'b1;
            ticks(2);
            check(firstMax[0], !k[0]);
            cntIn.addrClock <= 1'b0;
        end
        {cntIn.firstSelect, cntIn.secondSelect, cntIn.firstRead} <= 5'h06;
        counterDataIn <= 16'h05FF;
        pulse(2, 1);
        cntIn.wordClock <= 1'b1;
        ticks(2);
        check(secondMax, 2'b01);
        cntIn.wordClock <= 1'b0;
        ticks(4);
        expect16(16'h0600);
        check(counterDataOe_n, 2'b00);
        cntIn.firstSelect <= 2'b11;
        ticks(2);
        check(counterDataOe_n, 2'b11);
        grantIdle <= 1'b1;
        ticks(6);
        check(grantOutOe_n, 1'b0);
        grantIdle <= 1'b0;
        // Permit stays low until the grant is taken, since a driven holdoff pin blocks the request
        for (int c = 0; c < 3; c++) begin
            rdSel_n <= c[0];
            modSel_n <= !c[1];
            xfers = 0;
            {req, permit} <= 2'h2;
            waitFor(2, 1'b1);
            permit <= 1'b1;
            waitFor(0, 1'b1);
            ticks(12);
            modSel_n <= 1'b1;
            waitFor(0, 1'b0);
            check(16'(xfers), 16'h0004);
            check(holdoffOe_n, 1'b0);
            ticks(30);
            check(dmaRequestOe_n, 1'b1);
            permit <= 1'b0;
            waitFor(1, 1'b0);
            init_n <= 1'b0;
            ticks(1);
            check({busOut, dmaRequestOe_n}, 16'h0041);
            {req, permit, init_n} <= 3'h3;
            ticks(4);
        end
        conclude();
    end
endmodule

// ---- test/dmc_bus_partner.sv ----
// Bus-side model: arbiter grant, slave sync and reply, holdoff RC charge.
// Assumes the block's strobes and open-collector enables as inputs.
`timescale 1ns/100ps
module dmc_bus_partner (
    // Clock
    input  wire logic                     clk,
    // Block side
    input  wire logic                     dmaRequestOe_n,
    input  wire logic                     holdoffOe_n,
    input  wire dmc_pkg::dmc_bus_out_type busOut,
    input  wire logic                     grantIdle,
    // Bus side
    output logic                          seqClock,
    output logic                          grantIn_n,
    output logic                          syncSeen,
    output logic                          replySeen,
    output logic                          holdoffIn
);
    import dmc_pkg::*;
    logic [2:0] phase = 3'h0;
    logic [3:0] rc    = 4'h0;
    logic       busy  = 1'b0;
    // Reply is select acknowledge or a strobe delayed by a clk, so it is already high when a strobe starts
    always @(posedge clk) begin
        phase <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
        busy <= busOut.selectAck | busOut.dataInStrobe | busOut.dataOutStrobe;
        rc <= holdoffOe_n ? rc + {3'h0, rc != 4'hF} : 4'h0;
    end
    assign seqClock  = phase < 3'h2;
    assign grantIn_n = dmaRequestOe_n & ~grantIdle;
    assign syncSeen  = busOut.syncOut | busOut.selectAck;
    assign replySeen = busy;
    // Pin stays low while driven, and the RC charges slowly after release
    assign holdoffIn = holdoffOe_n & (rc == 4'hF);
endmodule
